// File: rtl/sar_dev.sv
// Converter end: framed conversion, serial result shift-out and power modes
`timescale 1ns/1ps

module sar_dev #(
  parameter int RES = sar_pkg::DEFAULT_RES
) (
  // Clock and reset
  input  wire logic               ref_clk_i,
  input  wire logic               reset_i,
  // Serial link
  sar_link_if.dev                 link,
  // Analog stand-in, sampled at frame start
  input  wire logic [RES-1:0]     sample_i,
  // Conversion results
  output      logic [RES-1:0]     result_o,
  output      logic               result_valid_o,
  output      logic               conv_abort_o,
  // Status
  output      logic               track_o,
  output      sar_pkg::sar_pwr_e  pwr_mode_o
);

  // ****************************************************************
  // Frame constants
  // ****************************************************************
  localparam int          PAD       = sar_pkg::SHIFT_BITS - 1 - RES;
  localparam logic [4:0]  CONV_L    = 5'(RES + 2);
  localparam logic [4:0]  TRACK_L   = 5'(RES + 1);
  localparam logic [4:0]  LAST_L    = 5'(sar_pkg::FRAME_CLKS - 1);
  localparam logic [4:0]  FRAME_L   = 5'(sar_pkg::FRAME_CLKS);
  localparam logic [4:0]  PD_LO_L   = 5'(sar_pkg::PD_FIRST_FALL);
  localparam logic [4:0]  PD_HI_L   = 5'(sar_pkg::PD_LAST_FALL);

  // ****************************************************************
  // Pin synchronisers and edge detection
  // ****************************************************************
  logic [1:0] sel_sync_q;
  logic [1:0] sclk_sync_q;
  logic       sel_prev_q;
  logic       sclk_prev_q;
  logic       sel_s;
  logic       sclk_s;
  logic       sel_fall;
  logic       sel_rise;
  logic       sclk_fall;
  logic       sclk_rise;

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sel_sync_q  <= 2'h3;
      sclk_sync_q <= 2'h3;
      sel_prev_q  <= 1'b1;
      sclk_prev_q <= 1'b1;
    end else begin
      sel_sync_q  <= {sel_sync_q[0], link.sel_n};
      sclk_sync_q <= {sclk_sync_q[0], link.sclk};
      sel_prev_q  <= sel_s;
      sclk_prev_q <= sclk_s;
    end
  end

  assign sel_s     = sel_sync_q[1];
  assign sclk_s    = sclk_sync_q[1];
  assign sel_fall  = sel_prev_q && !sel_s;
  assign sel_rise  = !sel_prev_q && sel_s;
  assign sclk_fall = sclk_prev_q && !sclk_s;
  assign sclk_rise = !sclk_prev_q && sclk_s;

  // ****************************************************************
  // Frame state and falling edge count
  // ****************************************************************
  logic       active_q;
  logic [4:0] fcnt_q;
  logic       fall_adv;
  logic       rise_seen;

  // Clock edges outside a frame, or past the 16th fall, do nothing
  assign fall_adv  = active_q && !sel_fall && sclk_fall && (fcnt_q != FRAME_L);
  assign rise_seen = active_q && !sel_fall && sclk_rise;

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      active_q <= 1'b0;
    end else if (sel_fall) begin
      active_q <= 1'b1;
    end else if (sel_rise) begin
      active_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      fcnt_q <= sar_pkg::COUNT_RESET;
    end else if (sel_fall) begin
      fcnt_q <= sar_pkg::COUNT_RESET;
    end else if (fall_adv) begin
      fcnt_q <= fcnt_q + 5'h01;
    end
  end

  // ****************************************************************
  // Result shifter
  // ****************************************************************
  logic [sar_pkg::SHIFT_BITS-1:0] sh_q;
  logic                           sdo_q;
  logic                           oe_n_q;
  logic [RES-1:0]                 held_q;

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sh_q  <= '0;
      sdo_q <= 1'b0;
    end else if (sel_fall) begin
      // Second leading zero, result, then trailing zeros
      sh_q  <= sar_pkg::SHIFT_BITS'({1'b0, sample_i}) << PAD;
      sdo_q <= 1'b0;
    end else if (fall_adv) begin
      sh_q  <= {sh_q[sar_pkg::SHIFT_BITS-2:0], 1'b0};
      sdo_q <= sh_q[sar_pkg::SHIFT_BITS-1];
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      held_q <= '0;
    end else if (sel_fall) begin
      held_q <= sample_i;
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      oe_n_q <= 1'b1;
    end else if (sel_fall) begin
      oe_n_q <= 1'b0;
    end else if (sel_rise) begin
      oe_n_q <= 1'b1;
    end else if (fall_adv && fcnt_q == LAST_L) begin
      oe_n_q <= 1'b1;
    end
  end

  // ****************************************************************
  // Sample stage
  // ****************************************************************
  logic track_q;

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      track_q <= 1'b1;
    end else if (sel_fall) begin
      track_q <= 1'b0;
    end else if (rise_seen && fcnt_q == TRACK_L) begin
      track_q <= 1'b1;
    end else if (sel_rise) begin
      // Aborted frame must not leave the stage stuck in hold
      track_q <= 1'b1;
    end
  end

  // ****************************************************************
  // Conversion completion and abort
  // ****************************************************************
  logic                  done_q;
  logic                  abort_q;
  logic [RES-1:0]        result_q;
  sar_pkg::sar_pwr_e     pwr_q;
  sar_pkg::sar_pwr_e     start_pwr_q;

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      done_q   <= 1'b0;
      result_q <= '0;
    end else begin
      // Dummy wake-up frames still load result_o but raise no result_valid_o
      done_q <= fall_adv && (fcnt_q == CONV_L - 5'h01) &&
                (start_pwr_q == sar_pkg::SAR_PWR_NORMAL);
      if (fall_adv && fcnt_q == CONV_L - 5'h01) begin
        result_q <= held_q;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      abort_q <= 1'b0;
    end else begin
      abort_q <= active_q && sel_rise && (fcnt_q < CONV_L);
    end
  end

  // ****************************************************************
  // Power modes
  // ****************************************************************
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      start_pwr_q <= sar_pkg::SAR_PWR_NORMAL;
    end else if (sel_fall) begin
      start_pwr_q <= pwr_q;
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pwr_q <= sar_pkg::SAR_PWR_NORMAL;
    end else if (fall_adv && fcnt_q == PD_HI_L - 5'h01) begin
      pwr_q <= sar_pkg::SAR_PWR_NORMAL;
    end else if (active_q && sel_rise && fcnt_q < PD_HI_L) begin
      if (start_pwr_q != sar_pkg::SAR_PWR_NORMAL) begin
        // No glitch guard when going to full power-down
        pwr_q <= sar_pkg::SAR_PWR_FULL;
      end else if (fcnt_q >= PD_LO_L) begin
        pwr_q <= sar_pkg::SAR_PWR_PARTIAL;
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign link.serial_result_out  = sdo_q;
  assign link.serial_result_oe_n = oe_n_q;
  assign result_o                = result_q;
  assign result_valid_o          = done_q;
  assign conv_abort_o            = abort_q;
  assign track_o                 = track_q;
  assign pwr_mode_o              = pwr_q;

endmodule

// File: rtl/sar_pkg.sv
// Shared constants and types for the converter serial readout link
package sar_pkg;

  // ****************************************************************
  // Frame geometry
  // ****************************************************************
  localparam int FRAME_CLKS    = 16;
  localparam int SHIFT_BITS    = 15;
  localparam int PD_FIRST_FALL = 2;
  localparam int PD_LAST_FALL  = 10;
  localparam int DEFAULT_RES   = 12;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS        = 5;
  localparam int ACQUIRE_WINDOW_NS    = 60;
  localparam int BUS_IDLE_GAP_NS      = 4;
  localparam int ACQUIRE_WINDOW_CYC   = (ACQUIRE_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUS_IDLE_GAP_CYC     = (BUS_IDLE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Acquisition and idle gap are not overlapped, trading a little rate for margin
  localparam int QUIET_CYC            = ACQUIRE_WINDOW_CYC + BUS_IDLE_GAP_CYC;
  localparam int SCLK_HALF_CYC        = 5;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [4:0]  COUNT_RESET = 5'h00;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    SAR_PWR_NORMAL,
    SAR_PWR_PARTIAL,
    SAR_PWR_FULL
  } sar_pwr_e;

  typedef enum logic [2:0] {
    SAR_H_IDLE,
    SAR_H_SETUP,
    SAR_H_LOW,
    SAR_H_HIGH,
    SAR_H_END,
    SAR_H_QUIET
  } sar_hst_e;

endpackage

// File: rtl/sar_link_if.sv
// Serial link between the converter end and its host
`timescale 1ns/1ps
interface sar_link_if;
  logic sel_n;
  logic sclk;
  logic serial_result_out;
  logic serial_result_oe_n;
  logic data_line;

  // Released line reads low, as with a weak pull-down
  assign data_line = serial_result_oe_n ? 1'b0 : serial_result_out;

  modport dev (
    input  sel_n,
    input  sclk,
    output serial_result_out,
    output serial_result_oe_n
  );

  modport host (
    output sel_n,
    output sclk,
    input  data_line,
    input  serial_result_oe_n
  );
endinterface

// File: rtl/sar_fifo.sv
// Word FIFO between the host receiver and its consumer
`timescale 1ns/1ps
module sar_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             reset_i,
  // Fill side
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output      logic             in_ready_o,
  // Drain side
  output      logic             out_valid_o,
  output      logic [WIDTH-1:0] out_data_o,
  input  wire logic             out_ready_i
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);
  localparam logic [AW:0]   FULL_CNT = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready_o  = (cnt_q != FULL_CNT);
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rd_q];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == LAST_IDX) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == LAST_IDX) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// File: rtl/sar_host.sv
// Host end: frames conversions, drives the serial clock, buffers words
`timescale 1ns/1ps
module sar_host #(
  parameter int SCLK_HALF = sar_pkg::SCLK_HALF_CYC,
  parameter int QUIET     = sar_pkg::QUIET_CYC,
  parameter int DEPTH     = 4
) (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  // Serial link
  sar_link_if.host         link,
  // Frame requests: clocks per frame, 1 to 16
  input  wire logic        req_valid_i,
  input  wire logic [4:0]  req_clks_i,
  output      logic        req_ready_o,
  // Received words
  output      logic        word_valid_o,
  output      logic [15:0] word_o,
  input  wire logic        word_ready_i,
  // Status
  output      logic        busy_o
);
  localparam logic [7:0] HALF_L  = 8'(SCLK_HALF - 1);
  localparam logic [7:0] QUIET_L = 8'(QUIET - 1);
  localparam logic [4:0] MAX_L   = 5'(sar_pkg::FRAME_CLKS);

  sar_pkg::sar_hst_e st_q;
  logic [7:0]  tmr_q;
  logic [4:0]  falls_q;
  logic [4:0]  len_q;
  logic [15:0] word_q;
  logic        sel_n_q;
  logic        sclk_q;
  logic        push_q;
  logic [1:0]  line_sync_q;
  logic        fifo_ready;
  logic        tick;
  logic        start;

  // ****************************************************************
  // Sequencing
  // ****************************************************************
  // Only one word per frame, so space checked at start is still there at push
  assign start = (st_q == sar_pkg::SAR_H_IDLE) && req_valid_i && fifo_ready;
  assign tick  = (st_q == sar_pkg::SAR_H_QUIET) ? (tmr_q == QUIET_L) : (tmr_q == HALF_L);

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_q    <= sar_pkg::SAR_H_IDLE;
      tmr_q   <= 8'h00;
      falls_q <= sar_pkg::COUNT_RESET;
      len_q   <= MAX_L;
    end else begin
      tmr_q <= (tick || st_q == sar_pkg::SAR_H_IDLE) ? 8'h00 : tmr_q + 8'h01;
      unique case (st_q)
        sar_pkg::SAR_H_IDLE: begin
          if (start) begin
            st_q    <= sar_pkg::SAR_H_SETUP;
            falls_q <= sar_pkg::COUNT_RESET;
            len_q   <= (req_clks_i == 5'h00) ? 5'h01 : ((req_clks_i > MAX_L) ? MAX_L : req_clks_i);
          end
        end
        sar_pkg::SAR_H_SETUP, sar_pkg::SAR_H_HIGH: begin
          if (tick) begin
            st_q    <= sar_pkg::SAR_H_LOW;
            falls_q <= falls_q + 5'h01;
          end
        end
        sar_pkg::SAR_H_LOW: begin
          if (tick) begin
            st_q <= (falls_q == len_q) ? sar_pkg::SAR_H_END : sar_pkg::SAR_H_HIGH;
          end
        end
        sar_pkg::SAR_H_END: begin
          if (tick) begin
            st_q <= sar_pkg::SAR_H_QUIET;
          end
        end
        sar_pkg::SAR_H_QUIET: begin
          if (tick) begin
            st_q <= sar_pkg::SAR_H_IDLE;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Pins
  // ****************************************************************
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sel_n_q <= 1'b1;
      sclk_q  <= 1'b1;
    end else begin
      if (start) begin
        sel_n_q <= 1'b0;
      end else if (st_q == sar_pkg::SAR_H_END && tick) begin
        sel_n_q <= 1'b1;
      end
      if (tick && (st_q == sar_pkg::SAR_H_SETUP || st_q == sar_pkg::SAR_H_HIGH)) begin
        sclk_q <= 1'b0;
      end else if (tick && st_q == sar_pkg::SAR_H_LOW) begin
        sclk_q <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Receive
  // ****************************************************************
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      line_sync_q <= 2'h0;
      word_q      <= sar_pkg::WORD_RESET;
      push_q      <= 1'b0;
    end else begin
      line_sync_q <= {line_sync_q[0], link.data_line};
      push_q      <= (st_q == sar_pkg::SAR_H_END) && tick;
      if (start) begin
        word_q <= sar_pkg::WORD_RESET;
      end else if (tick && (st_q == sar_pkg::SAR_H_SETUP || st_q == sar_pkg::SAR_H_HIGH)) begin
        // Synced line still shows the bit from before this fall
        word_q <= {word_q[14:0], line_sync_q[1]};
      end
    end
  end

  sar_fifo #(
    .WIDTH (16),
    .DEPTH (DEPTH)
  ) u_fifo (
    .ref_clk_i   (ref_clk_i),
    .reset_i     (reset_i),
    .in_valid_i  (push_q),
    .in_data_i   (word_q),
    .in_ready_o  (fifo_ready),
    .out_valid_o (word_valid_o),
    .out_data_o  (word_o),
    .out_ready_i (word_ready_i)
  );

  assign link.sel_n  = sel_n_q;
  assign link.sclk   = sclk_q;
  assign req_ready_o = (st_q == sar_pkg::SAR_H_IDLE) && fifo_ready;
  assign busy_o      = (st_q != sar_pkg::SAR_H_IDLE);

endmodule

// File: tb/sar_link_sva.sv
// Link checker: select, serial clock and data line timing
`timescale 1ns/1ps
module sar_link_sva (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Link
  input wire logic sel_n,
  input wire logic sclk,
  input wire logic serial_result_out,
  input wire logic serial_result_oe_n,
  input wire logic data_line
);
  logic       sclk_q;
  logic [4:0] falls_q;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  // ****************************************************************
  // Pin-side fall count
  // ****************************************************************
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) sclk_q <= 1'b1;
    else sclk_q <= sclk;
  end

  // Counted on the pins, ahead of the device's own synchroniser
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) falls_q <= 5'h00;
    else if (sel_n) falls_q <= 5'h00;
    else if (sclk_q && !sclk) falls_q <= falls_q + 5'h01;
  end

  // ****************************************************************
  // Properties
  // ****************************************************************
  property p_hold_drive;
    $fell(sel_n) |-> ##[1:5] !serial_result_oe_n;
  endproperty
  a_hold_drive: assert property (p_hold_drive)
    else $error("output not driven after select fall");

  property p_first_zero;
    $fell(sel_n) |-> ##4 (!serial_result_oe_n && !serial_result_out);
  endproperty
  a_first_zero: assert property (p_first_zero)
    else $error("first leading zero missing");

  property p_abort_release;
    $rose(sel_n) |-> ##[1:5] serial_result_oe_n;
  endproperty
  a_abort_release: assert property (p_abort_release)
    else $error("output not released after select rise");

  property p_release_16;
    (falls_q == 5'h10) |-> ##[1:5] serial_result_oe_n;
  endproperty
  a_release_16: assert property (p_release_16)
    else $error("output not released after fall 16");

  property p_drive_frame;
    (!sel_n && falls_q != 5'h00 && falls_q < 5'h10) |-> !serial_result_oe_n;
  endproperty
  a_drive_frame: assert property (p_drive_frame)
    else $error("output released inside frame");

  property p_idle_release;
    sel_n [*6] |-> (serial_result_oe_n && !data_line);
  endproperty
  a_idle_release: assert property (p_idle_release)
    else $error("output driven while deselected");

  property p_quiet_gap;
    $rose(sel_n) |-> sel_n [*8] ##1 sel_n [*5];
  endproperty
  a_quiet_gap: assert property (p_quiet_gap)
    else $error("select low too soon after frame");

  property p_sclk_idle;
    sel_n |-> sclk;
  endproperty
  a_sclk_idle: assert property (p_sclk_idle)
    else $error("serial clock low outside frame");

  property p_max_falls;
    !sel_n |-> (falls_q <= 5'h10);
  endproperty
  a_max_falls: assert property (p_max_falls)
    else $error("more than 16 clocks in frame");
endmodule

// File: tb/sar_adc_serial_readout_tb_top.sv
// End-to-end bench: host and device at three resolutions
`timescale 1ns/1ps
module sar_adc_serial_readout_tb_top;
  logic        ref_clk_i;
  logic        reset_i;
  logic        req_valid;
  logic [4:0]  req_clks;
  logic        word_ready;
  logic [11:0] smp;
  wire  [2:0]  req_ready;
  wire  [2:0]  word_valid;
  wire  [2:0]  busy;
  wire  [2:0]  res_valid;
  wire  [2:0]  abort;
  wire  [2:0]  track;
  wire  [15:0] word [3];
  wire  [11:0] result [3];
  wire  [1:0]  pwr [3];
  sar_pkg::sar_pwr_e pm [3];
  int          n_rv [3] = '{0, 0, 0};
  int          n_ab [3] = '{0, 0, 0};
  int          trk_at [3] = '{0, 0, 0};
  int          n_fail = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          falls = 0;
  logic        sclk_d;
  logic [15:0] fq [4][3];
  int          ftab [9] = '{16, 14, 10, 13, 8, 8, 16, 1, 16};
  logic [11:0] stab [9] = '{12'ha5c, 12'h3f1, 12'hc36, 12'h7e9, 12'h555, 12'haaa, 12'h123, 12'h9b4, 12'hfff};

  // ****************************************************************
  // Ends, one pair for each resolution
  // ****************************************************************
  for (genvar g = 0; g < 3; g++) begin : g_end
    localparam int R = 12 - 2 * g;
    logic [R-1:0] r;
    sar_link_if u_sar_link_if ();
    sar_dev #(.RES(R)) u_sar_dev (
      .ref_clk_i      (ref_clk_i),
      .reset_i        (reset_i),
      .link           (u_sar_link_if.dev),
      .sample_i       (smp[11 -: R]),
      .result_o       (r),
      .result_valid_o (res_valid[g]),
      .conv_abort_o   (abort[g]),
      .track_o        (track[g]),
      .pwr_mode_o     (pwr[g])
    );
    assign result[g] = 12'(r);
    sar_host u_sar_host (
      .ref_clk_i    (ref_clk_i),
      .reset_i      (reset_i),
      .link         (u_sar_link_if.host),
      .req_valid_i  (req_valid),
      .req_clks_i   (req_clks),
      .req_ready_o  (req_ready[g]),
      .word_valid_o (word_valid[g]),
      .word_o       (word[g]),
      .word_ready_i (word_ready),
      .busy_o       (busy[g])
    );
  end

  sar_link_sva u_sar_link_sva (
    .ref_clk_i          (ref_clk_i),
    .reset_i            (reset_i),
    .sel_n              (g_end[0].u_sar_link_if.sel_n),
    .sclk               (g_end[0].u_sar_link_if.sclk),
    .serial_result_out  (g_end[0].u_sar_link_if.serial_result_out),
    .serial_result_oe_n (g_end[0].u_sar_link_if.serial_result_oe_n),
    .data_line          (g_end[0].u_sar_link_if.data_line)
  );

  // ****************************************************************
  // Monitors and checks
  // ****************************************************************
  always @(posedge ref_clk_i) begin
    sclk_d <= g_end[0].u_sar_link_if.sclk;
    if (g_end[0].u_sar_link_if.sel_n) falls <= 0;
    else if (sclk_d && !g_end[0].u_sar_link_if.sclk) falls <= falls + 1;
    for (int g = 0; g < 3; g++) begin
      if (res_valid[g] === 1'b1) n_rv[g] <= n_rv[g] + 1;
      if (abort[g] === 1'b1) n_ab[g] <= n_ab[g] + 1;
      if (!g_end[0].u_sar_link_if.sel_n && falls > 0 && track[g] === 1'b1 && trk_at[g] == 0) trk_at[g] <= falls;
    end
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      results();
    end
  end

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    if (n_fail == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Word as the host shifts it: two zeros, result, trailing zeros
  function automatic logic [15:0] exp_word(input int res, input int n, input logic [11:0] s);
    logic [15:0] v;
    v = 16'(s >> (12 - res)) << (14 - res);
    return v >> (16 - n);
  endfunction

  task automatic pop(input logic [15:0] e [3], input bit cmp);
    int t;
    t = 0;
    while (word_valid[0] !== 1'b1 && t < 50) begin
      @(negedge ref_clk_i);
      t++;
    end
    for (int g = 0; g < 3; g++) begin
      chk("word_valid", 16'(word_valid[g]), 16'h0001);
      if (cmp) chk("word", word[g], e[g]);
    end
    word_ready = 1'b1;
    @(negedge ref_clk_i);
    word_ready = 1'b0;
    // Let an edge pass so a following pop never re-raises ready in this step
    @(negedge ref_clk_i);
  endtask

  task automatic frame(input int n, input bit popw, output logic [15:0] e [3]);
    int t;
    int rv0 [3];
    int ab0 [3];
    sar_pkg::sar_pwr_e st [3];
    t = 0;
    while (req_ready[0] !== 1'b1 && t < 100) begin
      @(negedge ref_clk_i);
      t++;
    end
    chk("req_ready", 16'(req_ready[0]), 16'h0001);
    for (int g = 0; g < 3; g++) begin
      rv0[g] = n_rv[g];
      ab0[g] = n_ab[g];
      trk_at[g] = 0;
      st[g] = pm[g];
      e[g] = exp_word(12 - 2 * g, n, smp);
    end
    req_valid = 1'b1;
    req_clks = 5'(n);
    @(negedge ref_clk_i);
    req_valid = 1'b0;
    t = 0;
    while (busy[0] !== 1'b0 && t < 400) begin
      @(negedge ref_clk_i);
      t++;
    end
    chk("busy", 16'(busy[0]), 16'h0000);
    for (int g = 0; g < 3; g++) begin
      int res;
      bit ok;
      res = 12 - 2 * g;
      ok = st[g] == sar_pkg::SAR_PWR_NORMAL && n >= res + 2;
      chk("result_valid", 16'(n_rv[g] - rv0[g]), 16'(ok));
      chk("abort", 16'(n_ab[g] - ab0[g]), 16'(n < res + 2));
      if (ok) begin
        chk("result", 16'(result[g]), 16'(smp >> (12 - res)));
        chk("track_at", 16'(trk_at[g]), 16'(res + 1));
      end
      pm[g] = (n >= 10) ? sar_pkg::SAR_PWR_NORMAL : (st[g] != sar_pkg::SAR_PWR_NORMAL) ? sar_pkg::SAR_PWR_FULL :
              (n >= 2) ? sar_pkg::SAR_PWR_PARTIAL : sar_pkg::SAR_PWR_NORMAL;
      chk("pwr", 16'(pwr[g]), 16'(pm[g]));
      chk("track", 16'(track[g]), 16'h0001);
    end
    if (popw) pop(e, st[0] == sar_pkg::SAR_PWR_NORMAL);
  endtask

  // ****************************************************************
  // Stimulus
  // ****************************************************************
  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end

  initial begin
    logic [15:0] e [3];
    reset_i = 1'b1;
    req_valid = 1'b0;
    req_clks = 5'h00;
    word_ready = 1'b0;
    smp = 12'h000;
    for (int g = 0; g < 3; g++) pm[g] = sar_pkg::SAR_PWR_NORMAL;
    repeat (2) @(negedge ref_clk_i);
    reset_i = 1'b0;
    foreach (ftab[i]) begin
      smp = stab[i];
      frame(ftab[i], 1'b1, e);
    end
    // Consumer stalls until the buffer refuses further frames
    for (int i = 0; i < 4; i++) begin
      smp = 12'h801 + 12'(i * 17);
      frame(16, 1'b0, fq[i]);
    end
    repeat (4) @(negedge ref_clk_i);
    chk("req_ready_full", 16'(req_ready), 16'h0000);
    for (int i = 0; i < 4; i++) pop(fq[i], 1'b1);
    chk("word_valid_empty", 16'(word_valid), 16'h0000);
    frame(16, 1'b1, e);
    results();
  end
endmodule
